// ==== verilog/sfds_pkg.sv ====
package sfds_pkg;
   // ****************************************************************
   // register map, byte addresses on the Avalon slave
   // ****************************************************************
   localparam logic [7:0] ADDR_FIFO_DMA = 8'h1C;
   localparam logic [7:0] ADDR_INT_FLAGS = 8'h20;
   localparam logic [7:0] ADDR_MODE = 8'h40;
   localparam logic [7:0] ADDR_DATA = 8'h44;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int BIT_TX_DMA_EN = 15;
   localparam int BIT_TX_FLUSH = 7;
   localparam int BIT_TX_FIFO_EN = 6;
   localparam int BIT_RX_DMA_EN = 31;
   localparam int FL_RECEIVE_QUEUE_UNDERRUN_FLAG = 15;
   localparam int FL_RECEIVE_QUEUE_OVERRUN_FLAG = 14;
   localparam int FL_SEND_QUEUE_UNDERRUN_FLAG = 13;
   localparam int FL_SEND_QUEUE_OVERRUN_FLAG = 12;
   localparam int FL_MST_DONE = 11;
   localparam int FL_ABORT = 9;
   localparam int FL_FAULT = 8;
   localparam int FL_SS_DEASSERT = 5;
   localparam int FL_SS_ASSERT = 4;
   localparam int FL_RX_FULL = 3;
   localparam int FL_RX_THD = 2;
   localparam int FL_TX_EMPTY = 1;
   localparam int FL_TX_THD = 0;
   localparam logic [15:0] FLAGS_IMPL = 16'hFB3F;
   localparam logic [15:0] FLAGS_TX = 16'h3003;
   localparam logic [15:0] FLAGS_RST = 16'h0002;
   localparam logic [4:0] TX_THD_RST = 5'h10;
   localparam logic [4:0] RX_THD_RST = 5'h00;
   localparam logic [2:0] SYNC_RST = 3'h2;

   // ****************************************************************
   // fifo geometry and serial clock timing
   // ****************************************************************
   localparam int FIFO_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam logic [6:0] LVL_FULL = 7'h20;
   localparam int CLK_NS = 50;
   localparam int SCK_HALF_NS = 500;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic busy;
      logic [31:0] rdata;
      logic tx_dma_en;
      logic tx_fifo_en;
      logic [4:0] tx_thd;
      logic rx_dma_en;
      logic [4:0] rx_thd;
      logic master;
      logic mm_en;
      logic [15:0] char_cnt;
      logic [15:0] flags;
      logic [PTR_W-1:0] tx_wp;
      logic [PTR_W-1:0] tx_rp;
      logic [6:0] tx_lvl;
      logic [PTR_W-1:0] rx_wp;
      logic [PTR_W-1:0] rx_rp;
      logic [6:0] rx_lvl;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync3;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic loaded;
      logic [15:0] chars;
      logic [7:0] div;
      logic sck;
      logic sdo;
      logic ss_out_n;
      logic tx_dreq;
      logic rx_dreq;
   } sfds_state_s;
endpackage

// ==== verilog/sfds_core.sv ====
// Function
// RULE_01 - clearing tx dma enable drops request
// RULE_02 - tx level field shows fifo bytes
// RULE_03 - flush one empties fifo, clears tx flags
// RULE_04 - flush zero changes nothing
// RULE_05 - software disables fifo before flushing
// RULE_06 - tx fifo enable bit, reset zero
// RULE_07 - below tx threshold: flag and dma
// RULE_08 - read of empty rx fifo: underrun
// RULE_09 - slave push into full rx: overrun
// RULE_10 - master stalls clock on rx full
// RULE_11 - slave fetch from empty tx: underrun
// RULE_12 - master stalls on empty tx, no flag
// RULE_13 - write to full tx fifo: overrun
// RULE_14 - master done after programmed characters
// RULE_15 - slave select early release: abort
// RULE_16 - multi-master select assertion sets fault
// RULE_17 - select edges set assert/deassert flags
// RULE_18 - rx fifo becoming full sets flag
// RULE_19 - rx threshold flag above level, clears below
// RULE_20 - tx empty flag, reset one
// RULE_21 - tx threshold flag set below, cleared above
// RULE_22 - rx threshold drives rx dma and flag
// RULE_23 - flags sticky, write one clears
//
// Local design decision: the Avalon-MM interface to the registers.
module sfds_core #(
   parameter int SCK_HALF_CYC = sfds_pkg::SCK_HALF_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic sck_i,
   input wire logic ss_n_i,
   input wire logic sdi_i,
   output logic sck_o,
   output logic sdo_o,
   output logic ss_n_o,
   output logic tx_dma_req_o,
   output logic rx_dma_req_o
);
   sfds_pkg::sfds_state_s s;
   sfds_pkg::sfds_state_s n;
   logic [7:0] tx_mem [sfds_pkg::FIFO_DEPTH];
   logic [7:0] rx_mem [sfds_pkg::FIFO_DEPTH];
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic flush;
   logic fire;
   logic [7:0] rx_byte;
   logic [15:0] set;
   logic [15:0] clr;
   logic [15:0] hwclr;
   logic [31:0] wm;
   logic [31:0] wd;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic rd;
      logic wr;
      logic sck_r;
      logic sck_f;
      logic ss_fall;
      logic ss_rise;
      logic tx_empty;
      logic rx_full;
      logic rise;
      logic fall;
      logic fetch;
      rd = 1'b0;
      wr = 1'b0;
      sck_r = 1'b0;
      sck_f = 1'b0;
      ss_fall = 1'b0;
      ss_rise = 1'b0;
      tx_empty = 1'b0;
      rx_full = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      fetch = 1'b0;
      n = s;
      wm = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}},
            {8{byteenable_i[0]}}};
      wd = writedata_i & wm;
      fire = (read_i || write_i) && !s.busy;
      wr = fire && write_i;
      rd = fire && read_i;
      // one wait cycle per access, then release for one cycle
      n.busy = !((read_i || write_i) && s.busy);
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      flush = 1'b0;
      set = '0;
      clr = '0;
      hwclr = '0;
      rx_byte = {s.shreg[6:0], s.sync2[0]};
      // pins: sync1 feeds only sync2
      n.sync1 = {sck_i, ss_n_i, sdi_i};
      n.sync2 = s.sync1;
      n.sync3 = s.sync2;
      sck_r = s.sync2[2] && !s.sync3[2];
      sck_f = !s.sync2[2] && s.sync3[2];
      ss_fall = !s.sync2[1] && s.sync3[1];
      ss_rise = s.sync2[1] && !s.sync3[1];
      tx_empty = (s.tx_lvl == 7'h00) || !s.tx_fifo_en;
      rx_full = (s.rx_lvl == sfds_pkg::LVL_FULL);

      // read data is prepared in the wait cycle
      if (read_i && s.busy) begin
         unique case (address_i)
            sfds_pkg::ADDR_FIFO_DMA: n.rdata = {s.rx_dma_en, s.rx_lvl, 3'h0, s.rx_thd,
               s.tx_dma_en, s.tx_lvl, 1'b0, s.tx_fifo_en, 1'b0, s.tx_thd}; // [RULE_02]
            sfds_pkg::ADDR_INT_FLAGS: n.rdata = {16'h0000, s.flags}; // [RULE_23]
            sfds_pkg::ADDR_MODE: n.rdata = {s.char_cnt, 14'h0000, s.mm_en, s.master};
            sfds_pkg::ADDR_DATA: n.rdata = {24'h000000, rx_mem[s.rx_rp]};
            default: n.rdata = 32'h00000000;
         endcase
      end

      // register writes take effect on the release edge
      if (wr) begin
         unique case (address_i)
            sfds_pkg::ADDR_FIFO_DMA: begin
               if (byteenable_i[1]) begin
                  n.tx_dma_en = wd[sfds_pkg::BIT_TX_DMA_EN];
               end
               if (byteenable_i[0]) begin
                  flush = wd[sfds_pkg::BIT_TX_FLUSH]; // [RULE_03] [RULE_04]
                  n.tx_fifo_en = wd[sfds_pkg::BIT_TX_FIFO_EN]; // [RULE_06]
                  n.tx_thd = wd[4:0];
               end
               if (byteenable_i[2]) begin
                  n.rx_thd = wd[20:16]; // [RULE_22]
               end
               if (byteenable_i[3]) begin
                  n.rx_dma_en = wd[sfds_pkg::BIT_RX_DMA_EN];
               end
            end
            sfds_pkg::ADDR_INT_FLAGS: clr = wd[15:0]; // [RULE_23]
            sfds_pkg::ADDR_MODE: begin
               if (byteenable_i[0]) begin
                  n.master = wd[0];
                  n.mm_en = wd[1];
               end
               if (byteenable_i[2]) begin
                  n.char_cnt[7:0] = wd[23:16];
               end
               if (byteenable_i[3]) begin
                  n.char_cnt[15:8] = wd[31:24];
               end
            end
            sfds_pkg::ADDR_DATA: begin
               if (byteenable_i[0]) begin
                  if (s.tx_lvl == sfds_pkg::LVL_FULL) begin
                     set[sfds_pkg::FL_SEND_QUEUE_OVERRUN_FLAG] = 1'b1; // [RULE_13]
                  end else if (s.tx_fifo_en) begin
                     tx_push = 1'b1; // [RULE_06]
                  end
               end
            end
            default: ;
         endcase
      end
      if (rd && address_i == sfds_pkg::ADDR_DATA) begin
         if (s.rx_lvl == 7'h00) begin
            set[sfds_pkg::FL_RECEIVE_QUEUE_UNDERRUN_FLAG] = 1'b1; // [RULE_08]
         end else begin
            rx_pop = 1'b1;
         end
      end

      // select edges are flagged in either mode
      if (ss_fall) begin
         set[sfds_pkg::FL_SS_ASSERT] = 1'b1; // [RULE_17]
      end
      if (ss_rise) begin
         set[sfds_pkg::FL_SS_DEASSERT] = 1'b1; // [RULE_17]
      end

      // shift engine, slave side follows the synchronised pins
      if (!s.master) begin
         n.sck = 1'b0;
         n.ss_out_n = 1'b1;
         n.loaded = 1'b0;
         n.div = 8'h00;
         if (ss_fall) begin
            n.bitcnt = 3'h0;
            fetch = 1'b1;
         end
         if (ss_rise && s.bitcnt != 3'h0) begin
            set[sfds_pkg::FL_ABORT] = 1'b1; // [RULE_15]
         end
         if (!s.sync2[1]) begin
            rise = sck_r;
            fall = sck_f;
         end
      end else begin
         // a select assertion while master with mm_en set is a contention fault
         if (ss_fall && s.mm_en) begin
            set[sfds_pkg::FL_FAULT] = 1'b1; // [RULE_16]
         end
         if (!s.loaded) begin
            n.div = 8'h00;
            // clock holds low until data and room are both there
            if (!tx_empty && !rx_full) begin // [RULE_10] [RULE_12]
               fetch = 1'b1;
               n.loaded = 1'b1;
               n.bitcnt = 3'h0;
               n.ss_out_n = 1'b0;
            end
         end else if (s.div == 8'(SCK_HALF_CYC - 1)) begin
            n.div = 8'h00;
            if (!s.sck) begin
               n.sck = 1'b1;
               rise = 1'b1;
            end else begin
               n.sck = 1'b0;
               fall = 1'b1;
               if (s.bitcnt == 3'h0) begin
                  n.loaded = 1'b0;
                  n.chars = s.chars + 16'h0001;
                  if (s.chars + 16'h0001 == s.char_cnt) begin
                     set[sfds_pkg::FL_MST_DONE] = 1'b1; // [RULE_14]
                     n.ss_out_n = 1'b1;
                     n.chars = 16'h0000;
                  end
               end
            end
         end else begin
            n.div = s.div + 8'h01;
         end
      end

      // sample on the rising edge, drive on the falling edge
      if (rise) begin
         n.shreg = rx_byte;
         n.bitcnt = s.bitcnt + 3'h1;
         if (s.bitcnt == 3'h7) begin
            if (rx_full) begin
               if (!s.master) begin
                  set[sfds_pkg::FL_RECEIVE_QUEUE_OVERRUN_FLAG] = 1'b1; // [RULE_09]
               end
            end else begin
               rx_push = 1'b1;
               if (s.rx_lvl == sfds_pkg::LVL_FULL - 7'h01) begin
                  set[sfds_pkg::FL_RX_FULL] = 1'b1; // [RULE_18]
               end
            end
            fetch = fetch || !s.master;
         end
      end
      if (fall) begin
         n.sdo = s.shreg[7];
      end
      if (fetch) begin
         if (tx_empty) begin
            // a slave must shift something out: zeros, flagged
            set[sfds_pkg::FL_SEND_QUEUE_UNDERRUN_FLAG] = !s.master; // [RULE_11] [RULE_12]
            n.shreg = 8'h00;
         end else begin
            tx_pop = 1'b1;
            n.shreg = tx_mem[s.tx_rp];
         end
         n.sdo = n.shreg[7];
      end

      // fifo pointers and levels
      n.tx_wp = s.tx_wp + PTR_W_ONE(tx_push);
      n.tx_rp = s.tx_rp + PTR_W_ONE(tx_pop);
      n.tx_lvl = s.tx_lvl + {6'h00, tx_push} - {6'h00, tx_pop};
      n.rx_wp = s.rx_wp + PTR_W_ONE(rx_push);
      n.rx_rp = s.rx_rp + PTR_W_ONE(rx_pop);
      n.rx_lvl = s.rx_lvl + {6'h00, rx_push} - {6'h00, rx_pop};
      if (flush) begin
         n.tx_wp = '0; // [RULE_03]
         n.tx_rp = '0;
         n.tx_lvl = 7'h00;
      end

      // level flags, hardware set wins over software clear
      set[sfds_pkg::FL_TX_EMPTY] = (s.tx_lvl == 7'h00); // [RULE_20]
      set[sfds_pkg::FL_TX_THD] = (s.tx_lvl < {2'b00, s.tx_thd}); // [RULE_07] [RULE_21]
      hwclr[sfds_pkg::FL_TX_THD] = (s.tx_lvl > {2'b00, s.tx_thd}); // [RULE_21]
      set[sfds_pkg::FL_RX_THD] = (s.rx_lvl > {2'b00, s.rx_thd}); // [RULE_19] [RULE_22]
      hwclr[sfds_pkg::FL_RX_THD] = (s.rx_lvl < {2'b00, s.rx_thd}); // [RULE_19]
      n.flags = ((s.flags & ~clr & ~hwclr) | set) & sfds_pkg::FLAGS_IMPL; // [RULE_23]
      if (flush) begin
         n.flags = n.flags & ~sfds_pkg::FLAGS_TX; // [RULE_03]
      end

      // dma requests drop on the same edge the enable clears
      n.tx_dreq = n.tx_dma_en && (s.tx_lvl < {2'b00, s.tx_thd}); // [RULE_01] [RULE_07]
      n.rx_dreq = n.rx_dma_en && (s.rx_lvl > {2'b00, s.rx_thd}); // [RULE_22]
   end

   function automatic logic [sfds_pkg::PTR_W-1:0] PTR_W_ONE(input logic b);
      return {{(sfds_pkg::PTR_W-1){1'b0}}, b};
   endfunction

   // ****************************************************************
   // state and fifo storage
   // ****************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.busy <= 1'b1;
         s.tx_thd <= sfds_pkg::TX_THD_RST;
         s.rx_thd <= sfds_pkg::RX_THD_RST;
         s.flags <= sfds_pkg::FLAGS_RST; // [RULE_20]
         s.sync1 <= sfds_pkg::SYNC_RST;
         s.sync2 <= sfds_pkg::SYNC_RST;
         s.sync3 <= sfds_pkg::SYNC_RST;
         s.ss_out_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // storage has no reset: levels guard every pop, but the rx data readback reads rx_mem even when empty
   always_ff @(posedge core_clk_i) begin
      if (tx_push) begin
         tx_mem[s.tx_wp] <= writedata_i[7:0];
      end
      if (rx_push) begin
         rx_mem[s.rx_wp] <= rx_byte;
      end
   end

   // outputs straight from the state register
   assign readdata_o = s.rdata;
   assign waitrequest_o = s.busy;
   assign sck_o = s.sck;
   assign sdo_o = s.sdo;
   assign ss_n_o = s.ss_out_n;
   assign tx_dma_req_o = s.tx_dreq;
   assign rx_dma_req_o = s.rx_dreq;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   dma_off_a: assert property (!n.tx_dma_en |=> !tx_dma_req_o) // [RULE_01]
      else $error("tx dma request survives disable");
   lvl_read_a: assert property (fire && read_i && address_i == sfds_pkg::ADDR_FIFO_DMA
      |-> readdata_o[14:8] == $past(s.tx_lvl)) // [RULE_02]
      else $error("tx level readback wrong");
   flush_clr_a: assert property (flush |=> s.tx_lvl == 7'h00
      && (s.flags & sfds_pkg::FLAGS_TX) == 16'h0000) // [RULE_03]
      else $error("flush left data or flags");
   tx_ovr_a: assert property (fire && write_i && address_i == sfds_pkg::ADDR_DATA
      && byteenable_i[0] && s.tx_lvl == sfds_pkg::LVL_FULL
      |=> s.flags[12] && s.tx_lvl == sfds_pkg::LVL_FULL) // [RULE_13]
      else $error("tx overrun not flagged");
   rx_und_a: assert property (fire && read_i && address_i == sfds_pkg::ADDR_DATA
      && s.rx_lvl == 7'h00 |=> s.flags[15]) // [RULE_08]
      else $error("rx underrun not flagged");
   tx_empty_a: assert property (s.tx_lvl == 7'h00 && !flush |=> s.flags[1]) // [RULE_20]
      else $error("tx empty flag missing");
   thd_dma_a: assert property (n.tx_dma_en && s.tx_lvl < {2'b00, s.tx_thd}
      |=> tx_dma_req_o && (s.flags[0] || $past(flush))) // [RULE_07]
      else $error("threshold did not raise dma");
   mst_stall_a: assert property (s.master |=> !$rose(s.flags[13])) // [RULE_12]
      else $error("master set tx underrun");
   sticky_a: assert property (s.flags[11] && !clr[11] |=> s.flags[11]) // [RULE_23]
      else $error("sticky flag lost");
   bus_ack_a: assert property ((read_i || write_i) && waitrequest_o
      |=> !waitrequest_o ##1 waitrequest_o)
      else $error("bus answer not one cycle");

   slave_char_c: cover property (rx_push && !s.master);
   mst_done_c: cover property (set[11]);
   flush_c: cover property (flush && s.tx_lvl != 7'h00);
   abort_c: cover property (set[9]);
endmodule // sfds_core

// ==== testbench/sfds_far_end.sv ====
// ****************************************************************
// remote serial device: drives frames into the block's slave side
// and answers the block when it acts as master
// ****************************************************************
module sfds_far_end (
   input wire logic core_clk_i,
   input wire logic sck_o,
   input wire logic sdo_o,
   input wire logic ss_n_o,
   output logic sck_i,
   output logic ss_n_i,
   output logic sdi_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got;
   logic [7:0] pat;
   logic sck_seen;

   // link idle: clock parked low, select released
   initial begin
      sck_i = 1'b0;
      ss_n_i = 1'b1;
      sdi_i = 1'b0;
      got = 8'h00;
      pat = 8'h5A;
      sck_seen = 1'b0;
   end

   // half of a 400 ns link period, in 50 ns core cycles
   task automatic wait_half;
      repeat (4) @(posedge core_clk_i);
   endtask

   // mode 0 frame, msb first; tail bits model an early release
   task automatic send(input logic [7:0] first, input int nbytes, input int tail);
      logic [7:0] b;
      ss_n_i <= 1'b0;
      for (int k = 0; k < nbytes * 8 + tail; k++) begin
         b = first + 8'(k / 8);
         sdi_i <= b[7 - k % 8];
         wait_half();
         sck_i <= 1'b1;
         got <= {got[6:0], sdo_o};
         wait_half();
         sck_i <= 1'b0;
      end
      wait_half();
      ss_n_i <= 1'b1;
      // released line shows the inverse so a stale value cannot pass
      sdi_i <= ~sdi_i;
   endtask

   // slave answer while the block is master: capture on rise, shift on fall
   always @(posedge core_clk_i) begin
      sck_seen <= sck_o;
      if (!ss_n_o && sck_o && !sck_seen) got <= {got[6:0], sdo_o};
      if (!ss_n_o && !sck_o && sck_seen) begin
         sdi_i <= pat[7];
         pat <= {pat[6:0], pat[7]};
      end
   end
endmodule // sfds_far_end

// ==== testbench/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // clock, reset and pins
   // ****************************************************************
   localparam logic [7:0] FD = sfds_pkg::ADDR_FIFO_DMA;
   localparam logic [7:0] FL = sfds_pkg::ADDR_INT_FLAGS;
   localparam logic [7:0] MD = sfds_pkg::ADDR_MODE;
   localparam logic [7:0] DT = sfds_pkg::ADDR_DATA;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] address_i = 8'h00;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h00000000;
   logic [31:0] readdata_o;
   logic [31:0] q;
   logic waitrequest_o, sck_i, ss_n_i, sdi_i, sck_o, sdo_o, ss_n_o;
   logic tx_dma_req_o, rx_dma_req_o;
   int errors = 0;
   int samples_checked = 0;

   // 20 MHz core clock
   always #25 core_clk_i = ~core_clk_i;

   // short serial clock half period keeps master runs brief
   sfds_core #(.SCK_HALF_CYC(2)) DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sck_i(sck_i),
      .ss_n_i(ss_n_i), .sdi_i(sdi_i), .sck_o(sck_o), .sdo_o(sdo_o), .ss_n_o(ss_n_o),
      .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o)
   );

   sfds_far_end far (
      .core_clk_i(core_clk_i), .sck_o(sck_o), .sdo_o(sdo_o), .ss_n_o(ss_n_o),
      .sck_i(sck_i), .ss_n_i(ss_n_i), .sdi_i(sdi_i)
   );

   // ****************************************************************
   // checking and bus tasks
   // ****************************************************************
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon access; held until waitrequest is sampled low
   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address_i <= a;
      writedata_i <= d;
      write_i <= wr_en;
      read_i <= ~wr_en;
      @(posedge core_clk_i);
      while (waitrequest_o !== 1'b0) begin
         n++;
         if (n > 50) begin
            errors++;
            final_report();
         end
         @(posedge core_clk_i);
      end
      q = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      // an idle edge so strobes are never driven twice in one step
      @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(q & m, exp);
   endtask

   task automatic settle;
      repeat (8) @(posedge core_clk_i);
   endtask

   // watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (60000) @(posedge core_clk_i);
      errors++;
      final_report();
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      rc(FD, 32'hFFFFFFFF, 32'h00000010);
      rc(FL, 32'hFFFFFFFF, 32'h00000003);
      rc(8'h80, 32'hFFFFFFFF, 32'h00000000);
      chk({31'h0, tx_dma_req_o}, 32'h0);
      $display("test reset values done");
      // three bytes queued, then dma on and off
      wr(FD, 32'h00000050);
      for (int i = 0; i < 3; i++) wr(DT, 32'hA0 + 32'(i));
      rc(FD, 32'hFFFFFFFF, 32'h00000350);
      wr(FD, 32'h00008050);
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, tx_dma_req_o}, 32'h1);
      wr(FD, 32'h00000050);
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, tx_dma_req_o}, 32'h0);
      wr(FL, 32'h00000000);
      rc(FL, 32'hFFFFFFFF, 32'h00000003);
      wr(FL, 32'h0000FFFF);
      rc(FL, 32'hFFFFFFFF, 32'h00000001);
      $display("test level, dma and sticky flags done");
      // 33rd byte overruns; flush zero keeps, flush one empties
      for (int i = 0; i < 30; i++) wr(DT, 32'h00000055);
      rc(FL, 32'hFFFFFFFF, 32'h00001000);
      rc(FD, 32'h00007F00, 32'h00002000);
      wr(FD, 32'h00000010);
      rc(FD, 32'hFFFFFFFF, 32'h00002010);
      rc(FL, 32'hFFFFFFFF, 32'h00001000);
      wr(FD, 32'h00000090);
      rc(FD, 32'hFFFFFFFF, 32'h00000010);
      rc(FL, 32'hFFFFFFFF, 32'h00000003);
      bus(1'b0, DT, 32'h00000000);
      rc(FL, 32'h00008000, 32'h00008000);
      $display("test overrun, flush and underrun done");
      // slave frames: one whole byte, then three bits and release
      wr(FD, 32'h00000050);
      wr(DT, 32'h000000C3);
      wr(FL, 32'h0000FFFF);
      far.send(8'h11, 1, 0);
      settle();
      chk({24'h0, far.got}, 32'h000000C3);
      // the slave reloads after the eighth bit, so an empty fifo underruns
      rc(FL, 32'h00002330, 32'h00002030);
      rc(DT, 32'h000000FF, 32'h00000011);
      wr(FL, 32'h0000FFFF);
      far.send(8'h00, 0, 3);
      settle();
      rc(FL, 32'h00002230, 32'h00002230);
      $display("test slave frames done");
      // receive fifo filled past full with threshold 1 and rx dma on
      wr(FD, 32'h80010050);
      wr(FL, 32'h0000FFFF);
      far.send(8'h20, 33, 0);
      settle();
      rc(FL, 32'h0000400C, 32'h0000400C);
      chk({31'h0, rx_dma_req_o}, 32'h1);
      // a master facing a full receive fifo keeps its clock parked
      wr(MD, 32'h00010001);
      wr(DT, 32'h0000003C);
      settle();
      chk({30'h0, ss_n_o, sck_o}, 32'h00000002);
      rc(FD, 32'h00007F00, 32'h00000100);
      for (int i = 0; i < 32; i++) rc(DT, 32'h000000FF, 32'h20 + 32'(i));
      // the first pop freed room: the master sent its byte and took one in
      rc(FD, 32'h7F007F00, 32'h01000000);
      bus(1'b0, DT, 32'h00000000);
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, rx_dma_req_o}, 32'h0);
      rc(FL, 32'h00000004, 32'h00000000);
      $display("test receive full done");
      // master sends two characters, then a multi-master fault
      wr(MD, 32'h00020001);
      wr(FL, 32'h0000FFFF);
      chk({30'h0, ss_n_o, sck_o}, 32'h00000002);
      wr(DT, 32'h0000003C);
      wr(DT, 32'h00000096);
      chk({31'h0, ss_n_o}, 32'h00000000);
      q = 32'h00000000;
      for (int i = 0; i < 100 && (q & 32'h800) == 32'h0; i++) bus(1'b0, FL, 32'h0);
      rc(FL, 32'h00006800, 32'h00000800);
      chk({24'h0, far.got}, 32'h00000096);
      chk({31'h0, ss_n_o}, 32'h00000001);
      wr(MD, 32'h00020003);
      wr(FL, 32'h0000FFFF);
      far.send(8'h00, 0, 0);
      settle();
      rc(FL, 32'h00000100, 32'h00000100);
      $display("test master and fault done");
      final_report();
   end
endmodule // tb
